// *** bench/pc_clock_output_control_tb.sv ***
`timescale 1ns/100ps
module pc_clock_output_control_tb;
    typedef struct packed {
        logic        wr;
        logic [11:0] addr;
        logic [31:0] data;
        logic        err;
    } pcoc_row_t;
    localparam pcoc_row_t ROWS [10] = '{
        '{1'b0, 12'h000, 32'h00000000, 1'b0}, '{1'b0, 12'h004, 32'h0FFFFFFF, 1'b0},
        '{1'b0, 12'h008, 32'h00000000, 1'b0}, '{1'b1, 12'h000, 32'hFFFFFFFF, 1'b0},
        '{1'b0, 12'h000, 32'h0000007F, 1'b0}, '{1'b1, 12'h000, 32'h00000000, 1'b0},
        '{1'b1, 12'h010, 32'h0000FFFF, 1'b1}, '{1'b0, 12'h010, 32'h00000000, 1'b1},
        '{1'b0, 12'hFFC, 32'h00000000, 1'b1}, '{1'b1, 12'h00C, 32'hFFFFFFFF, 1'b0}};
    localparam int FIDX [10] = '{0, 3, 12, 16, 21, 22, 23, 24, 26, 27};
    localparam int FEXP [10] = '{15, 10, 10, 30, 30, 21, 70, 70, 70, 70};
    localparam logic [3:0]  STOPS [6] = '{4'hF, 4'hE, 4'hC, 4'h8, 4'hF, 4'h7};
    localparam logic [27:0] MASKS [6] = '{28'hFFF0FFF, 28'hFFF0FF8, 28'hFE00FF8,
                                          28'hFE00000, 28'hFFF0FFF, 28'h0000000};
    logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [6:0]  strapPinIn, strapLevel;
    logic [3:0]  dualPinIn, stopReq;
    logic [27:0] clkOut, clkOeN;
    int          miscompares, num_checks;

    pcoc_clock_output_control pcoc_clock_output_control_inst (
        .core_clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .strapPinIn, .dualPinIn, .clkOut, .clkOeN);
    pcoc_clock_loads pcoc_clock_loads_inst (
        .core_clk, .clkOut, .clkOeN, .strapLevel, .stopReq, .pinLevel(), .strapPinIn,
        .dualPinIn);

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic fail_wait();
        check(32'h00000000, 32'hFFFFFFFF);
        end_sim();
    endtask : fail_wait

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) fail_wait();
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic high_len(input int idx, output int len);
        int n;
        n = 0;
        len = 0;
        while (clkOut[idx] !== 1'b0 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        while (clkOut[idx] !== 1'b1 && n < 800) begin
            @(posedge core_clk);
            n++;
        end
        while (clkOut[idx] === 1'b1 && len < 400) begin
            @(posedge core_clk);
            len++;
        end
        if (n >= 800 || len >= 400) fail_wait();
    endtask : high_len

    task automatic activity(input int cycles, output logic [27:0] seen);
        logic [27:0] prev;
        seen = 28'h0000000;
        prev = clkOut;
        repeat (cycles) begin
            @(posedge core_clk);
            seen = seen | (clkOut & ~prev);
            prev = clkOut;
        end
    endtask : activity

    task automatic do_reset(input logic [6:0] straps);
        logic [31:0] rd;
        logic        er;
        nrst       <= 1'b0;
        strapLevel <= straps;
        stopReq    <= 4'hF;
        repeat (4) @(posedge core_clk);
        check({4'h0, clkOut}, 32'h00000000);
        check({4'h0, clkOeN}, 32'h0FFFFFFF);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        apb(1'b0, 12'h00C, 32'h00000000, rd, er);
        check(rd & 32'h000000FF, {24'h000000, straps, 1'b1});
    endtask : do_reset

    initial begin
        logic [31:0] rd;
        logic        er;
        logic [27:0] seen;
        int          len, lo, hi;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        miscompares = 0;
        num_checks = 0;
        @(posedge core_clk);
        do_reset(7'h10);
        foreach (ROWS[i]) begin
            apb(ROWS[i].wr, ROWS[i].addr, ROWS[i].data, rd, er);
            if (!ROWS[i].wr) check(rd, ROWS[i].data);
            check({31'h0, er}, {31'h0, ROWS[i].err});
        end
        $display("test registers done");
        foreach (FIDX[i]) begin
            high_len(FIDX[i], len);
            check(32'(len), 32'(FEXP[i]));
        end
        activity(300, seen);
        check({4'h0, seen}, 32'h0FFFFFFF);
        $display("test strap rates done");
        apb(1'b1, 12'h004, 32'h0FFFFFFE, rd, er);
        apb(1'b1, 12'h008, 32'h00000002, rd, er);
        repeat (200) @(posedge core_clk);
        activity(300, seen);
        check({4'h0, seen}, 32'h0FFFFFFE);
        check({4'h0, clkOeN}, 32'h00000002);
        apb(1'b1, 12'h004, 32'h0FFFFFFF, rd, er);
        apb(1'b1, 12'h008, 32'h00000000, rd, er);
        $display("test enables done");
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, 12'h000, 32'(c * 2 + 1), rd, er);
            repeat (40) @(posedge core_clk);
            high_len(0, len);
            check(32'(len), 32'(pcoc_pkg::HOST_HALF[c]));
            high_len(3, len);
            check(32'(len), 32'(pcoc_pkg::SDRAM_HALF[c]));
            high_len(16, len);
            check(32'(len), 32'(pcoc_pkg::PCI_HALF[c]));
        end
        $display("test software codes done");
        for (int d = 0; d < 2; d++) begin
            apb(1'b1, 12'h000, d ? 32'h00000061 : 32'h00000021, rd, er);
            repeat (40) @(posedge core_clk);
            lo = 99;
            hi = 0;
            repeat (d ? 250 : 450) begin
                high_len(0, len);
                lo = (len < lo) ? len : lo;
                hi = (len > hi) ? len : hi;
            end
            check(32'(lo), 32'h0000000E);
            check(32'(hi), 32'h00000010);
        end
        apb(1'b1, 12'h000, 32'h00000000, rd, er);
        $display("test spread done");
        do_reset(7'h4D);
        high_len(0, len);
        check(32'(len), 32'(pcoc_pkg::HOST_HALF[13]));
        high_len(23, len);
        check(32'(len), 32'h0000002A);
        foreach (STOPS[i]) begin
            stopReq <= STOPS[i];
            repeat (300) @(posedge core_clk);
            activity(300, seen);
            check({4'h0, seen}, {4'h0, MASKS[i]});
        end
        $display("test power management done");
        end_sim();
    end
endmodule : pc_clock_output_control_tb

// *** bench/pcoc_clock_loads.sv ***
`timescale 1ns/100ps
module pcoc_clock_loads (
    input  wire logic        core_clk,
    input  wire logic [27:0] clkOut,
    input  wire logic [27:0] clkOeN,
    input  wire logic [6:0]  strapLevel,
    input  wire logic [3:0]  stopReq,
    output logic      [27:0] pinLevel,
    output logic      [6:0]  strapPinIn,
    output logic      [3:0]  dualPinIn
);
    localparam int PIN [7] = '{22, 21, 16, 25, 24, 26, 23};
    logic [27:0] floatPat_ff = 28'h0000000;

    // Released lines other than strap and dual pins wander so a stale level never passes for a driven one
    always_ff @(posedge core_clk) begin
        floatPat_ff <= ~pinLevel;
    end

    always_comb begin
        pinLevel = clkOut;
        for (int i = 0; i < 28; i++) begin
            if (clkOeN[i]) pinLevel[i] = floatPat_ff[i];
        end
        for (int i = 0; i < 4; i++) begin
            if (clkOeN[12 + i]) pinLevel[12 + i] = stopReq[i];
        end
        for (int i = 0; i < 7; i++) begin
            if (clkOeN[PIN[i]]) pinLevel[PIN[i]] = strapLevel[i];
            strapPinIn[i] = pinLevel[PIN[i]];
        end
        dualPinIn = pinLevel[15:12];
    end
endmodule : pcoc_clock_loads

// *** bench/pcoc_output_sva.sv ***
`timescale 1ns/100ps
module pcoc_output_sva (
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [6:0]  strapPinIn,
    input wire logic [3:0]  dualPinIn,
    input wire logic [27:0] clkOut,
    input wire logic [27:0] clkOeN
);
    logic        nrstQ_ff, modeCap_ff, nxt_modeCap;
    logic [11:0] triLo_ff, nxt_triLo;
    logic [7:0]  lowCnt_ff [4], nxt_lowCnt [4];
    wire logic   startEdge = nrst && !nrstQ_ff;

    // Stop counters saturate; 255 cycles covers the slowest gating wait
    always_comb begin
        nxt_modeCap = startEdge ? strapPinIn[pcoc_pkg::STRAP_MODE] : modeCap_ff;
        nxt_triLo = triLo_ff;
        if (!nrst) begin
            nxt_triLo = 12'h000;
        end else if (psel && penable && pready && pwrite && paddr == pcoc_pkg::REG_TRI) begin
            nxt_triLo = pwdata[11:0];
        end
        for (int i = 0; i < 4; i++) begin
            if (!nrst || modeCap_ff || dualPinIn[i]) begin
                nxt_lowCnt[i] = 8'h00;
            end else begin
                nxt_lowCnt[i] = lowCnt_ff[i] + {7'h00, lowCnt_ff[i] != 8'hFF};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        nrstQ_ff   <= nrst;
        modeCap_ff <= nxt_modeCap;
        triLo_ff   <= nxt_triLo;
        lowCnt_ff  <= nxt_lowCnt;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence apbSetup;
        psel && !penable;
    endsequence
    sequence triWrite;
        psel && penable && pready && pwrite && paddr == pcoc_pkg::REG_TRI;
    endsequence

    a_apb_answer: assert property (apbSetup |=> pready)
        else $error("setup unanswered");
    a_pready_single: assert property (pready |=> !pready)
        else $error("ready too long");
    a_err_unmapped: assert property ((apbSetup ##0 paddr > 12'h00C) |=> pready && pslverr)
        else $error("unmapped, no error");
    a_err_mapped: assert property ((apbSetup ##0 paddr <= 12'h00C && paddr[1:0] == 2'h0)
            |=> !pslverr)
        else $error("mapped with error");
    a_tri_follow: assert property (triWrite |-> ##[1:3] (clkOeN[11:0] == triLo_ff))
        else $error("tristate not applied");
    a_strap_first: assert property (startEdge |-> (clkOeN == '1 && clkOut == '0) [*2])
        else $error("driven before capture");
    a_dual_input: assert property (!modeCap_ff |-> clkOeN[15:12] == 4'hF
            && clkOut[15:12] == 4'h0)
        else $error("dual pins driven");
    a_host_stop: assert property (lowCnt_ff[0] == 8'hFF |-> clkOut[2:0] == 3'h0)
        else $error("host clocks run");
    a_pci_stop: assert property (lowCnt_ff[1] == 8'hFF |-> clkOut[20:16] == 5'h00)
        else $error("pci clocks run");
    a_sdram_stop: assert property (lowCnt_ff[2] == 8'hFF |-> clkOut[11:3] == 9'h000)
        else $error("sdram clocks run");
    a_pd_low: assert property (lowCnt_ff[3] == 8'hFF |-> clkOut == 28'h0000000)
        else $error("power down not low");
endmodule : pcoc_output_sva

bind pcoc_clock_output_control pcoc_output_sva pcoc_output_sva_inst (
    .core_clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
    .pslverr, .strapPinIn, .dualPinIn, .clkOut, .clkOeN
);

// *** logic/pcoc_clk_div.sv ***
`timescale 1ns/100ps
module pcoc_clk_div #(
    parameter int HALF_W = 8
) (
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire logic [HALF_W-1:0] halfPeriod,
    input  wire logic              spreadEn,
    input  wire logic              spreadDeep,
    output logic                   clkOut
);
    logic [HALF_W-1:0] cnt_ff,  nxt_cnt;
    logic [HALF_W-1:0] half_ff, nxt_half;
    logic              lvl_ff,  nxt_lvl;
    logic [7:0]        mod_ff,  nxt_mod;
    logic              up_ff,   nxt_up;

    if (HALF_W < 3) begin : g_chk
        $error("pcoc_clk_div: HALF_W too small");
    end

    always_comb begin
        logic [7:0]        step;
        logic [HALF_W-1:0] load;
        step     = spreadDeep ? pcoc_pkg::SPREAD_STEP_DEEP : pcoc_pkg::SPREAD_STEP_SHALLOW;
        load     = halfPeriod;
        nxt_cnt  = cnt_ff - 1'b1;
        nxt_half = half_ff;
        nxt_lvl  = lvl_ff;
        nxt_mod  = mod_ff;
        nxt_up   = up_ff;
        if (cnt_ff == '0) begin
            nxt_lvl = ~lvl_ff;
            if (!lvl_ff) begin
                // smooth change
                // New rate only at a period start, so no phase is cut short
                nxt_half = halfPeriod;
                // center spread
                // Alternate lengthen and shorten so the mean stays centred
                if (spreadEn && mod_ff == '0) begin
                    load   = up_ff ? halfPeriod + 1'b1 : halfPeriod - 1'b1;
                    nxt_up = ~up_ff;
                end
                nxt_mod = (mod_ff >= step) ? 8'h00 : mod_ff + 8'h01;
                nxt_cnt = load - 1'b1;
            end else begin
                nxt_cnt = half_ff - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cnt_ff  <= '0;
            half_ff <= '0;
            lvl_ff  <= 1'b0;
            mod_ff  <= 8'h00;
            up_ff   <= 1'b1;
        end else begin
            cnt_ff  <= nxt_cnt;
            half_ff <= nxt_half;
            lvl_ff  <= nxt_lvl;
            mod_ff  <= nxt_mod;
            up_ff   <= nxt_up;
        end
    end

    assign clkOut = lvl_ff;

endmodule : pcoc_clk_div

// *** logic/pcoc_clock_output_control.sv ***
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/100ps
// Overview of operation
// - Sixteen host rates chosen by straps plus ratio strap, or by software code.
// - Rate changes take effect only at period boundaries, never truncating pulses.
// - Software enables or disables each clock output individually.
// - Center spread modulation, depth 0.25% or 0.5% selectable.
// - Software puts each output into drive or high-impedance.
// - Mode strap 1 makes the four dual pins extra SDRAM clocks.
// - Mode strap 0: first dual pin, low, stops host clocks.
// - Mode strap 0: second dual pin, low, stops stoppable PCI clocks.
// - Mode strap 0: third dual pin, low, stops SDRAM clocks.
// - Mode strap 0: fourth dual pin, low, powers down all outputs.
// - Three frequency straps captured at power-up select host, SDRAM, PCI rates.
// - After capture, one frequency pin drives a never-stopped PCI clock.
// - After capture, lowest frequency strap pin drives the 48MHz USB clock.
// - Ratio strap captured at power-on joins the frequency selection.
// - Super-I/O pin strap: 0 gives 14.318MHz, 1 gives 24MHz.
// - Host-buffer-level strap captured, then its pin drives a reference clock.
// - Dedicated SDRAM clocks follow the host rate for matching selections.
// - Reference outputs and interrupt-controller reference run from the crystal rate.
// - Host and PCI start/stop waits free PCI rise, then own falling edge.
// - Stopped outputs sit low.
// - An output runs only if its enable and its stop input allow.
module pcoc_clock_output_control (
    input  wire logic                          core_clk,
    input  wire logic                          nrst,
    input  wire logic [pcoc_pkg::ADDR_W-1:0]   paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [pcoc_pkg::NSTRAP-1:0]   strapPinIn,
    input  wire logic [pcoc_pkg::NDUAL-1:0]    dualPinIn,
    output logic      [pcoc_pkg::NOUT-1:0]     clkOut,
    output logic      [pcoc_pkg::NOUT-1:0]     clkOeN
);
    localparam int NOUT = pcoc_pkg::NOUT;
    localparam int NFAM = pcoc_pkg::NFAM;
    localparam int HW   = pcoc_pkg::HALF_W;

    if (NOUT > 32 || pcoc_pkg::CTRL_W > 32) begin : g_chk
        $error("pcoc_clock_output_control: register fields exceed bus width");
    end

    // Pin synchronisers
    logic [pcoc_pkg::NSTRAP-1:0] strapS1_ff, strapS2_ff;
    logic [pcoc_pkg::NDUAL-1:0]  dualS1_ff,  dualS2_ff;

    always_ff @(posedge core_clk) begin
        strapS1_ff <= strapPinIn;
        strapS2_ff <= strapS1_ff;
        dualS1_ff  <= dualPinIn;
        dualS2_ff  <= dualS1_ff;
    end

    // Strap capture
    pcoc_pkg::pcoc_phase_t       phase_ff, nxt_phase;
    logic [pcoc_pkg::NSTRAP-1:0] strap_ff, nxt_strap;

    always_comb begin
        // strap hold
        // Follows the pins through reset and the first edge after, then frozen
        nxt_strap = (phase_ff == pcoc_pkg::PH_STRAP) ? strapS2_ff : strap_ff;
        nxt_phase = pcoc_pkg::PH_RUN;
    end

    always_ff @(posedge core_clk) begin
        strap_ff <= nxt_strap;
        if (!nrst) begin
            phase_ff <= pcoc_pkg::PH_STRAP;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    // Power management decode
    logic run, pmMode, hostGo, pciGo, sdramGo, pdOk;
    assign run     = (phase_ff == pcoc_pkg::PH_RUN);
    assign pmMode  = run & ~strap_ff[pcoc_pkg::STRAP_MODE];
    assign hostGo  = ~pmMode | dualS2_ff[pcoc_pkg::DUAL_HOST_STOP];
    assign pciGo   = ~pmMode | dualS2_ff[pcoc_pkg::DUAL_PCI_STOP];
    assign sdramGo = ~pmMode | dualS2_ff[pcoc_pkg::DUAL_SDRAM_STOP];
    assign pdOk    = ~pmMode | dualS2_ff[pcoc_pkg::DUAL_PD];

    // Registers
    logic [pcoc_pkg::CTRL_W-1:0] ctrl_ff,  nxt_ctrl;
    logic [NOUT-1:0]             outEn_ff, nxt_outEn;
    logic [NOUT-1:0]             tri_ff,   nxt_tri;
    logic [31:0]                 rdata_ff, nxt_rdata;
    logic                        ready_ff, nxt_ready;
    logic                        err_ff,   nxt_err;
    logic                        hit;

    always_comb begin
        case (paddr)
            pcoc_pkg::REG_CTRL, pcoc_pkg::REG_OUTEN,
            pcoc_pkg::REG_TRI, pcoc_pkg::REG_STATUS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_outEn = outEn_ff;
        nxt_tri   = tri_ff;
        nxt_rdata = rdata_ff;
        nxt_err   = 1'b0;
        // No wait state: answer in the first access cycle
        nxt_ready = psel & ~penable;
        if (psel && !penable) begin
            nxt_err   = ~hit;
            nxt_rdata = 32'h00000000;
            case (paddr)
                pcoc_pkg::REG_CTRL:   nxt_rdata[pcoc_pkg::CTRL_W-1:0] = ctrl_ff;
                pcoc_pkg::REG_OUTEN:  nxt_rdata[NOUT-1:0] = outEn_ff;
                pcoc_pkg::REG_TRI:    nxt_rdata[NOUT-1:0] = tri_ff;
                pcoc_pkg::REG_STATUS: nxt_rdata[12:0] = {pmMode & ~pdOk, dualS2_ff,
                                                         strap_ff, run};
                default:              nxt_rdata = 32'h00000000;
            endcase
        end
        if (psel && penable && ready_ff && pwrite) begin
            case (paddr)
                pcoc_pkg::REG_CTRL:  nxt_ctrl = pwdata[pcoc_pkg::CTRL_W-1:0];
                pcoc_pkg::REG_OUTEN: nxt_outEn = pwdata[NOUT-1:0];
                pcoc_pkg::REG_TRI:   nxt_tri = pwdata[NOUT-1:0];
                default:             nxt_tri = tri_ff;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ctrl_ff  <= pcoc_pkg::CTRL_RST;
            outEn_ff <= pcoc_pkg::OUTEN_RST;
            tri_ff   <= pcoc_pkg::TRI_RST;
            rdata_ff <= 32'h00000000;
            ready_ff <= 1'b0;
            err_ff   <= 1'b0;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            outEn_ff <= nxt_outEn;
            tri_ff   <= nxt_tri;
            rdata_ff <= nxt_rdata;
            ready_ff <= nxt_ready;
            err_ff   <= nxt_err;
        end
    end

    assign prdata  = rdata_ff;
    assign pready  = ready_ff;
    assign pslverr = err_ff;

    // Rate selection
    logic [3:0]    code;
    logic [HW-1:0] half [NFAM];
    logic          spreadOn;

    always_comb begin
        code = ctrl_ff[pcoc_pkg::CTRL_SWSEL] ?
               ctrl_ff[pcoc_pkg::CTRL_CODE_HI:pcoc_pkg::CTRL_CODE_LO] :
               {strap_ff[pcoc_pkg::STRAP_SDSEL], strap_ff[pcoc_pkg::STRAP_FS2],
                strap_ff[pcoc_pkg::STRAP_FS1], strap_ff[pcoc_pkg::STRAP_FS0]};
        half[pcoc_pkg::FAM_HOST]  = pcoc_pkg::HOST_HALF[code];
        half[pcoc_pkg::FAM_SDRAM] = pcoc_pkg::SDRAM_HALF[code];
        half[pcoc_pkg::FAM_PCI]   = pcoc_pkg::PCI_HALF[code];
        half[pcoc_pkg::FAM_USB]   = pcoc_pkg::USB48_HALF;
        half[pcoc_pkg::FAM_SIO]   = strap_ff[pcoc_pkg::STRAP_SIO] ?
                                    pcoc_pkg::SIO24_HALF : pcoc_pkg::REF14_HALF;
        half[pcoc_pkg::FAM_REF]   = pcoc_pkg::REF14_HALF;
    end
    assign spreadOn = ctrl_ff[pcoc_pkg::CTRL_SPREAD_EN];

    // Family generators; fixed rates never see spread
    logic [NFAM-1:0] fam;
    logic [NFAM-1:0] famPrev_ff;
    logic            pciRise;

    for (genvar f = 0; f < NFAM; f++) begin : g_fam
        pcoc_clk_div #(
            .HALF_W     (HW)
        ) u_div (
            .core_clk   (core_clk),
            .nrst       (nrst),
            .halfPeriod (half[f]),
            .spreadEn   (spreadOn && f <= pcoc_pkg::FAM_PCI),
            .spreadDeep (ctrl_ff[pcoc_pkg::CTRL_SPREAD_DEEP]),
            .clkOut     (fam[f])
        );
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            famPrev_ff <= '0;
        end else begin
            famPrev_ff <= fam;
        end
    end
    assign pciRise = fam[pcoc_pkg::FAM_PCI] & ~famPrev_ff[pcoc_pkg::FAM_PCI];

    // Per-output gating
    for (genvar i = 0; i < NOUT; i++) begin : g_out
        localparam int         FI   = pcoc_pkg::fam_of(i);
        localparam logic [1:0] SK   = pcoc_pkg::stop_of(i);
        localparam bit         DUAL = (i >= pcoc_pkg::OUT_DUAL_LO &&
                                       i <= pcoc_pkg::OUT_DUAL_HI);
        logic gate_ff, nxt_gate;
        logic arm_ff,  nxt_arm;
        logic out_ff,  nxt_out;
        logic oe_ff,   nxt_oe;
        logic want, fall;

        always_comb begin
            case (SK)
                pcoc_pkg::STOP_HOST:  want = hostGo;
                pcoc_pkg::STOP_PCI:   want = pciGo;
                pcoc_pkg::STOP_SDRAM: want = sdramGo;
                default:              want = 1'b1;
            endcase
            want     = want & outEn_ff[i] & pdOk & run & ~(DUAL & pmMode);
            fall     = ~fam[FI] & famPrev_ff[FI];
            nxt_gate = gate_ff;
            nxt_arm  = arm_ff;
            if (want == gate_ff) begin
                nxt_arm = 1'b0;
            end else if (SK == pcoc_pkg::STOP_HOST || SK == pcoc_pkg::STOP_PCI) begin
                if (arm_ff && fall) begin
                    nxt_gate = want;
                    nxt_arm  = 1'b0;
                end else if (pciRise) begin
                    nxt_arm = 1'b1;
                end
            end else if (fall) begin
                nxt_gate = want;
            end
            nxt_out = fam[FI] & gate_ff;
            // shared pins drive
            // A dual pin is an input in power-management mode, so never driven then
            nxt_oe  = ~run | tri_ff[i] | (DUAL & pmMode);
        end

        always_ff @(posedge core_clk) begin
            if (!nrst) begin
                gate_ff <= 1'b0;
                arm_ff  <= 1'b0;
                out_ff  <= 1'b0;
                oe_ff   <= 1'b1;
            end else begin
                gate_ff <= nxt_gate;
                arm_ff  <= nxt_arm;
                out_ff  <= nxt_out;
                oe_ff   <= nxt_oe;
            end
        end

        assign clkOut[i] = out_ff;
        assign clkOeN[i] = oe_ff;
    end

endmodule : pcoc_clock_output_control

// *** logic/pcoc_pkg.sv ***
package pcoc_pkg;

    // Output slots
    localparam int NOUT         = 28;
    localparam int OUT_HOST_LO  = 0;
    localparam int OUT_HOST_HI  = 2;
    localparam int OUT_SDRAM_LO = 3;
    localparam int OUT_DUAL_LO  = 12;
    localparam int OUT_DUAL_HI  = 15;
    localparam int OUT_PCI0     = 16;
    localparam int OUT_PCI_HI   = 20;
    localparam int OUT_PCIF     = 21;
    localparam int OUT_USB      = 22;
    localparam int OUT_SIO      = 23;
    localparam int OUT_REF_A    = 24;
    localparam int OUT_REF_B    = 25;
    localparam int OUT_REF_C    = 26;
    localparam int OUT_IRQREF   = 27;

    // Strap pins
    localparam int NSTRAP        = 7;
    localparam int STRAP_FS0     = 0;
    localparam int STRAP_FS1     = 1;
    localparam int STRAP_FS2     = 2;
    localparam int STRAP_SDSEL   = 3;
    localparam int STRAP_MODE    = 4;
    localparam int STRAP_HOSTBUF = 5;
    localparam int STRAP_SIO     = 6;

    // Dual-purpose pins in power-management role
    localparam int NDUAL          = 4;
    localparam int DUAL_HOST_STOP = 0;
    localparam int DUAL_PCI_STOP  = 1;
    localparam int DUAL_SDRAM_STOP = 2;
    localparam int DUAL_PD        = 3;

    // Clock families
    localparam int NFAM      = 6;
    localparam int FAM_HOST  = 0;
    localparam int FAM_SDRAM = 1;
    localparam int FAM_PCI   = 2;
    localparam int FAM_USB   = 3;
    localparam int FAM_SIO   = 4;
    localparam int FAM_REF   = 5;

    localparam logic [1:0] STOP_NONE  = 2'h0;
    localparam logic [1:0] STOP_HOST  = 2'h1;
    localparam logic [1:0] STOP_PCI   = 2'h2;
    localparam logic [1:0] STOP_SDRAM = 2'h3;

    // APB map
    localparam int          ADDR_W     = 12;
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_OUTEN  = 12'h004;
    localparam logic [11:0] REG_TRI    = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00C;

    localparam int CTRL_W           = 7;
    localparam int CTRL_SWSEL       = 0;
    localparam int CTRL_CODE_LO     = 1;
    localparam int CTRL_CODE_HI     = 4;
    localparam int CTRL_SPREAD_EN   = 5;
    localparam int CTRL_SPREAD_DEEP = 6;
    localparam logic [6:0]  CTRL_RST  = 7'h00;
    localparam logic [27:0] OUTEN_RST = 28'hFFFFFFF;
    localparam logic [27:0] TRI_RST   = 28'h0000000;

    // Half periods in core cycles; one core cycle stands for 0.5 ns of output time
    localparam int HALF_W = 8;
    localparam logic [7:0] HOST_HALF [16] = '{
        8'h0F, 8'h0B, 8'h0A, 8'h0A, 8'h0A, 8'h09, 8'h08, 8'h07,
        8'h0F, 8'h0D, 8'h0C, 8'h0A, 8'h0A, 8'h09, 8'h08, 8'h07};
    localparam logic [7:0] SDRAM_HALF [16] = '{
        8'h0A, 8'h0B, 8'h10, 8'h0F, 8'h0D, 8'h0D, 8'h0C, 8'h0B,
        8'h0F, 8'h0D, 8'h0C, 8'h0A, 8'h0A, 8'h09, 8'h08, 8'h07};
    localparam logic [7:0] PCI_HALF [16] = '{
        8'h1E, 8'h21, 8'h20, 8'h1E, 8'h21, 8'h1B, 8'h20, 8'h1E,
        8'h1E, 8'h21, 8'h1E, 8'h20, 8'h1E, 8'h1B, 8'h20, 8'h1E};
    localparam logic [7:0] USB48_HALF = 8'h15;
    localparam logic [7:0] SIO24_HALF = 8'h2A;
    localparam logic [7:0] REF14_HALF = 8'h46;

    // Periods between one-cycle spread steps
    localparam logic [7:0] SPREAD_STEP_SHALLOW = 8'hC8;
    localparam logic [7:0] SPREAD_STEP_DEEP    = 8'h64;

    typedef enum logic {
        PH_STRAP = 1'b0,
        PH_RUN   = 1'b1
    } pcoc_phase_t;

    function automatic int fam_of(input int i);
        if (i <= OUT_HOST_HI) return FAM_HOST;
        if (i <= OUT_DUAL_HI) return FAM_SDRAM;
        if (i <= OUT_PCIF)    return FAM_PCI;
        if (i == OUT_USB)     return FAM_USB;
        if (i == OUT_SIO)     return FAM_SIO;
        return FAM_REF;
    endfunction : fam_of

    function automatic logic [1:0] stop_of(input int i);
        if (i <= OUT_HOST_HI) return STOP_HOST;
        if (i <= OUT_DUAL_HI) return STOP_SDRAM;
        if (i <= OUT_PCI_HI)  return STOP_PCI;
        return STOP_NONE;
    endfunction : stop_of

endpackage : pcoc_pkg
